// ==== gpio_wake_defines.vh ====
`ifndef GPIO_WAKE_DEFINES_VH
`define GPIO_WAKE_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_WAKE_STATUS_2 8'h00
`define OFS_WAKE_STATUS_3 8'h04
`define OFS_WAKE_STATUS_4 8'h08
`define OFS_WAKE_STATUS_5 8'h0C
`define OFS_WAKE_STATUS_7 8'h10
`define OFS_WAKE_ENABLE_2 8'h14
`define OFS_WAKE_ENABLE_3 8'h18
`define OFS_WAKE_ENABLE_4 8'h1C
`define OFS_WAKE_ENABLE_5 8'h20
`define OFS_WAKE_ENABLE_7 8'h24
`define OFS_MGMT_STATUS_3 8'h28
`define OFS_MGMT_STATUS_4 8'h2C
`define OFS_MGMT_STATUS_5 8'h30
`define OFS_MGMT_STATUS_7 8'h34
`define OFS_MGMT_ENABLE_3 8'h38
`define OFS_MGMT_ENABLE_4 8'h3C
`define OFS_MGMT_ENABLE_5 8'h40
`define OFS_MGMT_ENABLE_7 8'h44
`define OFS_DUAL_EDGE_STATUS 8'h48
`define OFS_GLOBAL_CTRL 8'h4C
`define OFS_POLARITY_LO 8'h50
`define OFS_POLARITY_HI 8'h54
`define OFS_DUAL_EDGE_CAPTURE 8'h58
`define OFS_PIN_DATA_LO 8'h5C
`define OFS_PIN_DATA_HI 8'h60

// ****************************************************************
// Field layout
// ****************************************************************
`define NUM_PINS 42
`define NUM_DUAL 6
`define BIT_GLOBAL_WAKE_EN 0
`define BIT_MGMT_SERIAL_ROUTE 1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define ZERO_8 8'h00
`define ZERO_32 32'h00000000

// Pin index map: port1 0-7, port2 8-15, port3 16-23, port5 24-31,
// port4 pin1 32, port4 pin3 33, port6 pin0 34, port6 pin1 35.
`define PIN_P2_7 8
`define PIN_P3_3 19
`define PIN_P5_3 27

`endif

// ==== gpio_wake_smi_event_logic.v ====
// How it works
// (R1) Every port one, two, three, five pin, port four pins 1,3, port six pins 0,1 has wake bits.
// (R2) Wake pair 2 port one, 3 port two, 5 port five, 4 mixed, 7 port three high.
// (R3) Interrupt bits exist for the same pins except port two pin 3.
// (R4) Interrupt pairs 3,4,5,7 map pins as listed; port one shares pair 5.
// (R5) Six pins capture both edges for wake and interrupt events.
// (R6) Each dual-edge pin also owns a collected dual-edge status bit.
// (R7) Exactly six dual-edge pins; others detect the polarity-selected edge only.
// (R8) Dual-edge capture ignores direction, polarity and driver type for events.
// (R9) Polarity still inverts the data bit read back for a dual-edge pin.
// (R10) Dual-edge pin requests only with capture selected and enable set.
// (R11) Status sets on each transition and clears only by writing one.
// (R12) One register shows all six dual-edge status bits.
// (R13) Status records events regardless of enables or capture selection.
// (R14) Software keeps port two pin 7 interrupt enable clear when it is the output.
// (R15) Software uses port two pin 7 as a source only with serial routing.
// (R16) Port three pin 3 comes up driven low as output after reset.
// (R17) Port three pin 3 is a non-inverting output with main supply removed.
// (R18) Port four pin 3 defaults to its general-purpose function after reset.
// (R19) Port five pin 3 comes up driven low as output after every reset.
// (R20) Port five pin 3 is a non-inverting output held low without main supply.
// (R21) Single-edge pins: polarity picks edge; non-inverted default means rising.
// (R22) Global wake enable gates the wake output.
// (R23) Status AND enable per event, ORed into the combined request.
// (R24) Inputs synchronised before edge detection; reset clears all status.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "gpio_wake_defines.vh"

module gpio_wake_smi_event_logic (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] port_one_pins,
  input wire [7:0] port_two_pins,
  input wire [7:0] port_three_pins,
  input wire [1:0] port_four_pins_1_3,
  input wire [7:0] port_five_pins,
  input wire [1:0] port_six_pins_0_1,
  input wire main_supply_present,
  output wire port_three_pin_3_out,
  output wire port_three_pin_3_oe,
  output wire port_five_pin_3_out,
  output wire port_five_pin_3_oe,
  output wire port_four_pin_3_gpio_sel,
  output reg wake_out,
  output reg mgmt_irq_out,
  output reg mgmt_irq_serial,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************************************
  // Pin gathering and synchronisation
  // ****************************************************************
  wire [`NUM_PINS-1:0] pins_raw;
  reg [`NUM_PINS-1:0] sync1_r;
  reg [`NUM_PINS-1:0] sync2_r;
  reg [`NUM_PINS-1:0] prev_r;

  // Upper six index bits 36-41 are unused padding, tied low.
  assign pins_raw = {6'h00, port_six_pins_0_1, port_four_pins_1_3, port_five_pins,
                     port_three_pins, port_two_pins, port_one_pins};

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= {`NUM_PINS{1'b0}};
      sync2_r <= {`NUM_PINS{1'b0}};
      prev_r <= {`NUM_PINS{1'b0}};
    end else begin
      sync1_r <= pins_raw; // (R24)
      sync2_r <= sync1_r; // (R24)
      prev_r <= sync2_r;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  reg [`NUM_PINS-1:0] wake_en_r;
  reg [`NUM_PINS-1:0] mgmt_en_r;
  reg [`NUM_PINS-1:0] polarity_r;
  reg [`NUM_PINS-1:0] wake_sts_r;
  reg [`NUM_PINS-1:0] mgmt_sts_r;
  reg [`NUM_DUAL-1:0] dual_capture_r;
  reg [`NUM_DUAL-1:0] dual_sts_r;
  reg global_wake_en_r;
  reg serial_route_r;

  // Which pins carry wake and interrupt bits, and which are dual-edge.
  localparam [`NUM_PINS-1:0] WAKE_MASK = 42'h00F_FFFF_FFFF; // (R1)
  localparam [`NUM_PINS-1:0] MGMT_MASK = 42'h00F_FFFF_F7FF; // (R3)
  localparam [`NUM_PINS-1:0] DUAL_MASK = 42'h00F_0000_0600; // (R7)

  wire [`NUM_PINS-1:0] dual_sel;
  wire [`NUM_PINS-1:0] event_hit;
  wire [`NUM_PINS-1:0] data_view;

  // Dual-edge pins in order: p2.1, p2.2, p4.1, p4.3, p6.0, p6.1.
  assign dual_sel = {6'h00, dual_capture_r[5:2], 21'h000000, dual_capture_r[1:0], 9'h000};

  genvar g;
  generate
    for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_pin
      wire rise = sync2_r[g] & ~prev_r[g];
      wire fall = ~sync2_r[g] & prev_r[g];
      // Dual-edge pins see both edges whether or not capture is selected.
      if (DUAL_MASK[g]) begin : g_dual
        assign event_hit[g] = rise | fall; // (R5) (R8) (R13)
      end else begin : g_single
        assign event_hit[g] = polarity_r[g] ? fall : rise; // (R21)
      end
      assign data_view[g] = sync2_r[g] ^ polarity_r[g]; // (R9)
    end
  endgenerate

  wire [`NUM_DUAL-1:0] dual_hit = {event_hit[35:32], event_hit[10:9]}; // (R6)

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire aw_have = aw_held_r | s_axi_awvalid;
  wire w_have = w_held_r | s_axi_wvalid;
  wire [7:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_go = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0] wb = ws[0] ? wd[7:0] : `ZERO_8;

  // Write-one-to-clear masks from byte 0 of each status write; interrupt status 5 also takes byte 1.
  reg [`NUM_PINS-1:0] wake_clr;
  reg [`NUM_PINS-1:0] mgmt_clr;
  reg [`NUM_DUAL-1:0] dual_clr;
  reg wr_ok;

  always @* begin
    wake_clr = {`NUM_PINS{1'b0}};
    mgmt_clr = {`NUM_PINS{1'b0}};
    dual_clr = {`NUM_DUAL{1'b0}};
    wr_ok = 1'b1;
    if (!wr_go) begin
      wr_ok = 1'b1;
    end else if (wa == `OFS_WAKE_STATUS_2) begin
      wake_clr[7:0] = wb; // (R11)
    end else if (wa == `OFS_WAKE_STATUS_3) begin
      wake_clr[15:8] = wb;
    end else if (wa == `OFS_WAKE_STATUS_4) begin
      wake_clr[19:16] = wb[3:0];
      wake_clr[32] = wb[4];
      wake_clr[33] = wb[5];
      wake_clr[34] = wb[6];
      wake_clr[35] = wb[7];
    end else if (wa == `OFS_WAKE_STATUS_5) begin
      wake_clr[31:24] = wb;
    end else if (wa == `OFS_WAKE_STATUS_7) begin
      wake_clr[23:20] = wb[3:0];
    end else if (wa == `OFS_MGMT_STATUS_3) begin
      mgmt_clr[15:8] = wb & 8'hF7;
      mgmt_clr[34] = wb[3];
    end else if (wa == `OFS_MGMT_STATUS_4) begin
      mgmt_clr[19:16] = wb[3:0];
      mgmt_clr[32] = wb[4];
      mgmt_clr[33] = wb[5];
      mgmt_clr[35] = wb[6];
    end else if (wa == `OFS_MGMT_STATUS_5) begin
      mgmt_clr[31:24] = wb;
      mgmt_clr[7:0] = ws[1] ? wd[15:8] : `ZERO_8;
    end else if (wa == `OFS_MGMT_STATUS_7) begin
      mgmt_clr[23:20] = wb[3:0];
    end else if (wa == `OFS_DUAL_EDGE_STATUS) begin
      dual_clr = wb[5:0]; // (R11)
    end else if (wa > `OFS_PIN_DATA_HI) begin
      wr_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= `ZERO_8;
      wdata_r <= `ZERO_32;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Enables, polarity and status
  // ****************************************************************
  wire ws0 = wr_go & ws[0];
  wire ws1 = wr_go & ws[1];

  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_en_r <= {`NUM_PINS{1'b0}};
      mgmt_en_r <= {`NUM_PINS{1'b0}};
      polarity_r <= {`NUM_PINS{1'b0}};
      dual_capture_r <= {`NUM_DUAL{1'b0}};
      global_wake_en_r <= 1'b0;
      serial_route_r <= 1'b0;
      wake_sts_r <= {`NUM_PINS{1'b0}}; // (R24)
      mgmt_sts_r <= {`NUM_PINS{1'b0}}; // (R24)
      dual_sts_r <= {`NUM_DUAL{1'b0}}; // (R24)
    end else begin
      // Hardware set wins over a same-cycle software clear.
      wake_sts_r <= ((wake_sts_r & ~wake_clr) | event_hit) & WAKE_MASK; // (R11) (R13)
      mgmt_sts_r <= ((mgmt_sts_r & ~mgmt_clr) | event_hit) & MGMT_MASK; // (R11) (R13)
      dual_sts_r <= (dual_sts_r & ~dual_clr) | dual_hit; // (R6) (R11)
      if (ws0 && wa == `OFS_WAKE_ENABLE_2) begin
        wake_en_r[7:0] <= wd[7:0]; // (R2)
      end else if (ws0 && wa == `OFS_WAKE_ENABLE_3) begin
        wake_en_r[15:8] <= wd[7:0];
      end else if (ws0 && wa == `OFS_WAKE_ENABLE_4) begin
        wake_en_r[19:16] <= wd[3:0];
        wake_en_r[35:32] <= wd[7:4];
      end else if (ws0 && wa == `OFS_WAKE_ENABLE_5) begin
        wake_en_r[31:24] <= wd[7:0];
      end else if (ws0 && wa == `OFS_WAKE_ENABLE_7) begin
        wake_en_r[23:20] <= wd[3:0];
      end else if (ws0 && wa == `OFS_MGMT_ENABLE_3) begin
        mgmt_en_r[15:8] <= wd[7:0] & 8'hF7; // (R4)
        mgmt_en_r[34] <= wd[3];
      end else if (ws0 && wa == `OFS_MGMT_ENABLE_4) begin
        mgmt_en_r[19:16] <= wd[3:0];
        mgmt_en_r[33:32] <= wd[5:4];
        mgmt_en_r[35] <= wd[6];
      end else if (wr_go && wa == `OFS_MGMT_ENABLE_5) begin
        if (ws[0]) mgmt_en_r[31:24] <= wd[7:0];
        if (ws[1]) mgmt_en_r[7:0] <= wd[15:8];
      end else if (ws0 && wa == `OFS_MGMT_ENABLE_7) begin
        mgmt_en_r[23:20] <= wd[3:0];
      end else if (ws0 && wa == `OFS_GLOBAL_CTRL) begin
        global_wake_en_r <= wd[`BIT_GLOBAL_WAKE_EN];
        serial_route_r <= wd[`BIT_MGMT_SERIAL_ROUTE];
      end else if (wr_go && wa == `OFS_POLARITY_LO) begin
        if (ws[0]) polarity_r[7:0] <= wd[7:0];
        if (ws[1]) polarity_r[15:8] <= wd[15:8];
        if (ws[2]) polarity_r[23:16] <= wd[23:16];
        if (ws[3]) polarity_r[31:24] <= wd[31:24];
      end else if (ws0 && wa == `OFS_POLARITY_HI) begin
        polarity_r[35:32] <= wd[3:0];
      end else if (ws0 && wa == `OFS_DUAL_EDGE_CAPTURE) begin
        dual_capture_r <= wd[5:0];
      end
    end
  end

  // ****************************************************************
  // Request outputs
  // ****************************************************************
  // Dual-edge pins request only while capture is selected for them.
  wire [`NUM_PINS-1:0] req_gate = ~DUAL_MASK | dual_sel; // (R10)
  wire wake_any = |(wake_sts_r & wake_en_r & req_gate); // (R23)
  wire mgmt_any = |(mgmt_sts_r & mgmt_en_r & req_gate); // (R23)

  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_out <= 1'b0;
      mgmt_irq_out <= 1'b0;
      mgmt_irq_serial <= 1'b0;
    end else begin
      wake_out <= wake_any & global_wake_en_r; // (R22)
      mgmt_irq_out <= mgmt_any & ~serial_route_r;
      mgmt_irq_serial <= mgmt_any & serial_route_r; // (R15)
    end
  end

  // Fan and infrared pins drive low after reset and without main supply.
  assign port_three_pin_3_out = 1'b0; // (R16) (R17)
  assign port_three_pin_3_oe = 1'b1; // (R16) (R17)
  assign port_five_pin_3_out = 1'b0; // (R19) (R20)
  assign port_five_pin_3_oe = 1'b1; // (R19) (R20)
  assign port_four_pin_3_gpio_sel = 1'b1; // (R18)

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [31:0] rd_val;
  reg rd_ok;

  always @* begin
    rd_val = `ZERO_32;
    rd_ok = 1'b1;
    if (s_axi_araddr == `OFS_WAKE_STATUS_2) rd_val[7:0] = wake_sts_r[7:0];
    else if (s_axi_araddr == `OFS_WAKE_STATUS_3) rd_val[7:0] = wake_sts_r[15:8];
    else if (s_axi_araddr == `OFS_WAKE_STATUS_4) rd_val[7:0] = {wake_sts_r[35:32], wake_sts_r[19:16]};
    else if (s_axi_araddr == `OFS_WAKE_STATUS_5) rd_val[7:0] = wake_sts_r[31:24];
    else if (s_axi_araddr == `OFS_WAKE_STATUS_7) rd_val[3:0] = wake_sts_r[23:20];
    else if (s_axi_araddr == `OFS_WAKE_ENABLE_2) rd_val[7:0] = wake_en_r[7:0];
    else if (s_axi_araddr == `OFS_WAKE_ENABLE_3) rd_val[7:0] = wake_en_r[15:8];
    else if (s_axi_araddr == `OFS_WAKE_ENABLE_4) rd_val[7:0] = {wake_en_r[35:32], wake_en_r[19:16]};
    else if (s_axi_araddr == `OFS_WAKE_ENABLE_5) rd_val[7:0] = wake_en_r[31:24];
    else if (s_axi_araddr == `OFS_WAKE_ENABLE_7) rd_val[3:0] = wake_en_r[23:20];
    else if (s_axi_araddr == `OFS_MGMT_STATUS_3)
      rd_val[7:0] = {mgmt_sts_r[15:12], mgmt_sts_r[34], mgmt_sts_r[10:8]};
    else if (s_axi_araddr == `OFS_MGMT_STATUS_4)
      rd_val[6:0] = {mgmt_sts_r[35], mgmt_sts_r[33:32], mgmt_sts_r[19:16]};
    else if (s_axi_araddr == `OFS_MGMT_STATUS_5) rd_val[15:0] = {mgmt_sts_r[7:0], mgmt_sts_r[31:24]};
    else if (s_axi_araddr == `OFS_MGMT_STATUS_7) rd_val[3:0] = mgmt_sts_r[23:20];
    else if (s_axi_araddr == `OFS_MGMT_ENABLE_3)
      rd_val[7:0] = {mgmt_en_r[15:12], mgmt_en_r[34], mgmt_en_r[10:8]};
    else if (s_axi_araddr == `OFS_MGMT_ENABLE_4)
      rd_val[6:0] = {mgmt_en_r[35], mgmt_en_r[33:32], mgmt_en_r[19:16]};
    else if (s_axi_araddr == `OFS_MGMT_ENABLE_5) rd_val[15:0] = {mgmt_en_r[7:0], mgmt_en_r[31:24]};
    else if (s_axi_araddr == `OFS_MGMT_ENABLE_7) rd_val[3:0] = mgmt_en_r[23:20];
    else if (s_axi_araddr == `OFS_DUAL_EDGE_STATUS) rd_val[5:0] = dual_sts_r; // (R12)
    else if (s_axi_araddr == `OFS_GLOBAL_CTRL) rd_val[1:0] = {serial_route_r, global_wake_en_r};
    else if (s_axi_araddr == `OFS_POLARITY_LO) rd_val = polarity_r[31:0];
    else if (s_axi_araddr == `OFS_POLARITY_HI) rd_val[3:0] = polarity_r[35:32];
    else if (s_axi_araddr == `OFS_DUAL_EDGE_CAPTURE) rd_val[5:0] = dual_capture_r;
    else if (s_axi_araddr == `OFS_PIN_DATA_LO) rd_val = data_view[31:0]; // (R9)
    else if (s_axi_araddr == `OFS_PIN_DATA_HI) rd_val[3:0] = data_view[35:32];
    else rd_ok = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `ZERO_32;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // gpio_wake_smi_event_logic

// ==== gpio_wake_event_props.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Port-level checker for the pin event logic
// ****************************************************************
module gpio_wake_event_props (
  input wire aclk,
  input wire aresetn,
  input wire port_three_pin_3_out,
  input wire port_three_pin_3_oe,
  input wire port_five_pin_3_out,
  input wire port_five_pin_3_oe,
  input wire port_four_pin_3_gpio_sel,
  input wire wake_out,
  input wire mgmt_irq_out,
  input wire mgmt_irq_serial,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // Only a register write may lower a request, so a quiet bus keeps it up.
  wire quiet = !(s_axi_awvalid && s_axi_awready) && !(s_axi_wvalid && s_axi_wready);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fan_pin_low_a: assert property (!port_three_pin_3_out && port_three_pin_3_oe)
    else $error("fan pin is not a low output");
  ir_pin_low_a: assert property (!port_five_pin_3_out && port_five_pin_3_oe)
    else $error("infrared pin is not a low output");
  gpio_func_a: assert property (port_four_pin_3_gpio_sel)
    else $error("port four pin 3 left its general-purpose function");
  reset_quiet_a: assert property ($rose(aresetn) |-> !wake_out && !mgmt_irq_out && !mgmt_irq_serial)
    else $error("request raised straight out of reset");
  route_excl_a: assert property (!(mgmt_irq_out && mgmt_irq_serial))
    else $error("management request on both routes");
  wake_hold_a: assert property (quiet [*4] ##0 wake_out |=> wake_out)
    else $error("wake request dropped without a write");
  irq_hold_a: assert property (quiet [*4] ##0 (mgmt_irq_out || mgmt_irq_serial) |=> (mgmt_irq_out || mgmt_irq_serial))
    else $error("management request dropped without a write");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h60 |=>
    s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wake_seen_c: cover property ($rose(wake_out));
  serial_seen_c: cover property ($rose(mgmt_irq_serial));
  refused_seen_c: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // gpio_wake_event_props

// ==== pin_event_source.sv ====
`timescale 1ns/1ps
// ****************************************************************
// External wake sources: pins change just after a clock edge
// ****************************************************************
module pin_event_source (
  input wire aclk,
  input wire [35:0] level_req,
  output logic [7:0] port_one_pins = 8'h00,
  output logic [7:0] port_two_pins = 8'h00,
  output logic [7:0] port_three_pins = 8'h00,
  output logic [1:0] port_four_pins_1_3 = 2'h0,
  output logic [7:0] port_five_pins = 8'h00,
  output logic [1:0] port_six_pins_0_1 = 2'h0
);
  always @(posedge aclk) begin
    {port_six_pins_0_1, port_four_pins_1_3, port_five_pins, port_three_pins, port_two_pins, port_one_pins} <= level_req;
  end
endmodule // pin_event_source

// ==== gpio_wake_smi_event_logic_tb.sv ====
`timescale 1ns/1ps
`include "gpio_wake_defines.vh"
// ****************************************************************
// Self-checking bench with a pin-event model
// ****************************************************************
module gpio_wake_smi_event_logic_tb;
  logic aclk = 1'b0, aresetn = 1'b0, main_supply_present = 1'b1;
  logic [35:0] lvl = 36'h0, ws = 36'h0, pol = 36'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire [7:0] port_one_pins, port_two_pins, port_three_pins, port_five_pins;
  wire [1:0] port_four_pins_1_3, port_six_pins_0_1, s_axi_bresp, s_axi_rresp;
  wire p33_out, p33_oe, p53_out, p53_oe, gpio_sel, wake_out, mgmt_irq_out, mgmt_irq_serial;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [31:0] s_axi_rdata;
  int err_count = 0, comparisons = 0, cycles = 0;
  logic [31:0] rd_data;
  logic [1:0] rd_resp, wr_resp;
  localparam logic [7:0] CHK [0:11] = '{`OFS_WAKE_STATUS_2, `OFS_WAKE_STATUS_3, `OFS_WAKE_STATUS_4,
    `OFS_WAKE_STATUS_5, `OFS_WAKE_STATUS_7, `OFS_MGMT_STATUS_3, `OFS_MGMT_STATUS_4, `OFS_MGMT_STATUS_5,
    `OFS_MGMT_STATUS_7, `OFS_DUAL_EDGE_STATUS, `OFS_PIN_DATA_LO, `OFS_PIN_DATA_HI};

  pin_event_source src (.level_req(lvl), .*);
  gpio_wake_smi_event_logic dut (.port_three_pin_3_out(p33_out), .port_three_pin_3_oe(p33_oe),
    .port_five_pin_3_out(p53_out), .port_five_pin_3_oe(p53_oe), .port_four_pin_3_gpio_sel(gpio_sel),
    .s_axi_wstrb(4'hF), .*);

  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Bready and rready come one cycle late, so the slave must hold its answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, done;
    aw = 1'b1;
    w = 1'b1;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) begin
        done = 1'b1;
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end else if (!aw && !w) s_axi_bready <= 1'b1;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, done;
    ar = 1'b1;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1'b1;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end else if (!ar) s_axi_rready <= 1'b1;
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  function automatic logic [31:0] exp_reg(input logic [7:0] a);
    case (a)
      `OFS_WAKE_STATUS_2: exp_reg = {24'h0, ws[7:0]};
      `OFS_WAKE_STATUS_3: exp_reg = {24'h0, ws[15:8]};
      `OFS_WAKE_STATUS_4: exp_reg = {24'h0, ws[35:32], ws[19:16]};
      `OFS_WAKE_STATUS_5: exp_reg = {24'h0, ws[31:24]};
      `OFS_WAKE_STATUS_7: exp_reg = {28'h0, ws[23:20]};
      `OFS_MGMT_STATUS_3: exp_reg = {24'h0, ws[15:12], ws[34], ws[10:8]};
      `OFS_MGMT_STATUS_4: exp_reg = {25'h0, ws[35], ws[33:32], ws[19:16]};
      `OFS_MGMT_STATUS_5: exp_reg = {16'h0, ws[7:0], ws[31:24]};
      `OFS_MGMT_STATUS_7: exp_reg = {28'h0, ws[23:20]};
      `OFS_DUAL_EDGE_STATUS: exp_reg = {26'h0, ws[35:32], ws[10:9]};
      `OFS_PIN_DATA_LO: exp_reg = lvl[31:0] ^ pol[31:0];
      default: exp_reg = {28'h0, lvl[35:32] ^ pol[35:32]};
    endcase
  endfunction

  task automatic check_all;
    for (int i = 0; i < 12; i++) begin
      rd(CHK[i]);
      chk_word("status word", exp_reg(CHK[i]), rd_data);
    end
  endtask

  task automatic clear_all;
    for (int i = 0; i < 10; i++) wr(CHK[i], 32'hFFFFFFFF);
    ws = 36'h0;
  endtask

  task automatic set_pins(input logic [35:0] v);
    for (int i = 0; i < 36; i++) begin
      if (i == 9 || i == 10 || i >= 32) ws[i] = ws[i] | (lvl[i] ^ v[i]);
      else ws[i] = ws[i] | (pol[i] ? (lvl[i] & ~v[i]) : (~lvl[i] & v[i]));
    end
    lvl <= v;
    repeat (8) @(posedge aclk);
  endtask

  initial begin
    void'($urandom(32'h478027C3));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check_all();
    chk_word("fixed pins", 32'h0000000B, {27'h0, p33_out, p33_oe, p53_out, p53_oe, gpio_sel});
    chk_bit("wake request", 1'b0, wake_out);
    $display("test reset done");
    pol = {4'($urandom()), $urandom()};
    wr(`OFS_POLARITY_LO, pol[31:0]);
    wr(`OFS_POLARITY_HI, {28'h0, pol[35:32]});
    wr(`OFS_DUAL_EDGE_CAPTURE, {26'h0, 6'($urandom())});
    clear_all();
    repeat (12) set_pins({4'($urandom()), $urandom()});
    check_all();
    clear_all();
    check_all();
    $display("test random edges done");
    set_pins(36'h0);
    pol = 36'h0;
    wr(`OFS_POLARITY_LO, 32'h0);
    wr(`OFS_POLARITY_HI, 32'h0);
    wr(`OFS_DUAL_EDGE_CAPTURE, 32'h0);
    clear_all();
    wr(`OFS_WAKE_ENABLE_2, 32'h000000FF);
    wr(`OFS_GLOBAL_CTRL, 32'h0);
    wr(`OFS_MGMT_ENABLE_3, 32'h0000007F);
    set_pins(36'h000000101);
    chk_bit("wake request", 1'b0, wake_out);
    chk_bit("mgmt request", 1'b1, mgmt_irq_out);
    wr(`OFS_GLOBAL_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    chk_bit("wake request", 1'b1, wake_out);
    wr(`OFS_GLOBAL_CTRL, 32'h3);
    repeat (3) @(posedge aclk);
    chk_bit("mgmt pin request", 1'b0, mgmt_irq_out);
    chk_bit("mgmt serial request", 1'b1, mgmt_irq_serial);
    clear_all();
    repeat (3) @(posedge aclk);
    chk_bit("wake request", 1'b0, wake_out);
    chk_bit("mgmt serial request", 1'b0, mgmt_irq_serial);
    wr(`OFS_WAKE_ENABLE_4, 32'h00000080);
    set_pins(36'h800000101);
    check_all();
    chk_bit("wake request", 1'b0, wake_out);
    wr(`OFS_DUAL_EDGE_CAPTURE, 32'h00000020);
    repeat (3) @(posedge aclk);
    chk_bit("wake request", 1'b1, wake_out);
    $display("test requests done");
    rd(8'h64);
    chk_word("unmapped read", 32'h00000002, {30'h0, rd_resp});
    chk_word("unmapped data", 32'h0, rd_data);
    wr(8'h64, 32'h0);
    chk_word("unmapped write", 32'h00000002, {30'h0, wr_resp});
    main_supply_present <= 1'b0;
    repeat (3) @(posedge aclk);
    chk_word("fixed pins", 32'h0000000B, {27'h0, p33_out, p33_oe, p53_out, p53_oe, gpio_sel});
    $display("test refusals and supply done");
    end_of_test();
  end
endmodule // gpio_wake_smi_event_logic_tb

bind gpio_wake_smi_event_logic gpio_wake_event_props props (.*);
